// File: src/uoc_ctrl.sv
// Purpose: Control, address, token, frame threshold and configuration registers
//    of a USB On-The-Go controller, with their effects on the bus side.
// Assumes: Serial engine signals share ref_clk; line levels come from pins.
// Notes: Every output is registered; token launch shows on the edge that takes a write, other effects one cycle later.
// Contract
// - Live single-ended-zero flag reads 1 while both lines are low, both views.
// - Packet disable stops the engine; set by hardware on a received SETUP.
// - Host enable turns on host mode and pull-downs on both lines.
// - Pointer reset held at 1 forces all ping-pong pointers to even bank.
// - Module enable in device mode attaches by driving the D+ pull-up.
// - Host view shows a live J-state flag, polarity depending on speed.
// - Host view shows token busy while a token executes.
// - With frame start enabled in host mode a SOF token goes every 1 ms.
// - Low-speed select makes host run at low speed, else full speed.
// - Seven-bit device address, read/write, cleared at reset.
// - In device mode the low-speed bit reads 0 and is not stored.
// - Token codes: SETUP 1101, IN 1001, OUT 0001; others reserved.
// - Eye-pattern test runs while its enable is 1 and the module runs.
// - Output-enable monitor drives active-low line-driving flag when enabled.
// - The monitor acts only while the transceiver is disabled.
// - Stop-in-idle halts the module while the processor idles.
// - Ping-pong config: 11 EP1-15, 10 all, 01 EP0 OUT, 00 none.
// - Unimplemented bits and upper byte ignore writes, read 0.
// - Transceiver disable routes the bus to the external digital interface.
`timescale 1ns/1ps
module uoc_ctrl #(
   parameter int SOF_CYCLES = uoc_pkg::SOF_PERIOD_CYCLES
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [15:0] reg_rdata,
   // Bus line levels from the receiver
   input wire logic line_dp,
   input wire logic line_dm,
   // Serial engine events and status
   input wire logic setup_token_seen,
   input wire logic token_done,
   input wire logic tx_driving,
   input wire logic cpu_idle,
   // Module and pull resistor controls
   output logic module_run,
   output logic dp_pullup_on,
   output logic dp_pulldown_on,
   output logic dm_pulldown_on,
   output logic engine_halt,
   output logic resume_drive,
   output logic bus_reset_drive,
   output logic low_speed_mode,
   output logic [6:0] device_address,
   // Host token issue
   output logic token_start,
   output logic [3:0] token_type_code,
   output logic [3:0] token_endpoint_number,
   output logic sof_send,
   output logic [7:0] frame_threshold_count,
   // Configuration effects
   output logic eye_test_run,
   output logic xcvr_off,
   output logic drive_oe_n,
   output logic ptr_force_even,
   output logic pp_ep0_out_en,
   output logic pp_ep0_in_en,
   output logic pp_ep_upper_en
);

   // Stored control and configuration bits
   logic pkt_dis_reg;
   logic host_en_reg;
   logic resume_reg;
   logic ptr_reset_reg;
   logic attach_reg;
   logic bus_reset_reg;
   logic sof_en_reg;
   logic tok_busy_reg;
   logic low_speed_reg;
   logic [6:0] addr_reg;
   logic [7:0] token_reg;
   logic [7:0] thresh_reg;
   logic eye_reg;
   logic oe_mon_reg;
   logic stop_idle_reg;
   logic [1:0] ppb_reg;
   logic xcvr_dis_reg;
   logic [1:0] line_meta_reg;
   logic [1:0] line_sync_reg;
   logic [31:0] sof_cnt_reg;

   // Line synchroniser: the first stage feeds only the second
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         line_meta_reg <= 2'h0;
         line_sync_reg <= 2'h0;
      end else begin
         line_meta_reg <= {line_dp, line_dm};
         line_sync_reg <= line_meta_reg;
      end
   end

   // Live line state decode
   wire dp_s = line_sync_reg[1];
   wire dm_s = line_sync_reg[0];
   wire se0_live = !dp_s && !dm_s;
   wire j_live = low_speed_reg ? (dm_s && !dp_s) : (dp_s && !dm_s);

   // Address decode
   wire wr_ctrl = reg_write && (reg_addr == uoc_pkg::ADDR_CONTROL);
   wire wr_addr = reg_write && (reg_addr == uoc_pkg::ADDR_FUNC_ADDR);
   wire wr_tok = reg_write && (reg_addr == uoc_pkg::ADDR_TOKEN);
   wire wr_sof = reg_write && (reg_addr == uoc_pkg::ADDR_SOF_THRESH);
   wire wr_cfg = reg_write && (reg_addr == uoc_pkg::ADDR_CONFIG_FIRST);
   wire wr_xcvr = reg_write && (reg_addr == uoc_pkg::ADDR_CONFIG_XCVR);

   // Token code check: reserved codes store but never launch a token
   wire [3:0] new_type = reg_wdata[7:4];
   wire type_ok = (new_type == uoc_pkg::TOK_SETUP) || (new_type == uoc_pkg::TOK_IN)
      || (new_type == uoc_pkg::TOK_OUT);
   wire tok_launch = wr_tok && host_en_reg && type_ok && !tok_busy_reg;

   // Idle halt; the module only runs when enabled in some mode
   wire idle_halt = stop_idle_reg && cpu_idle;
   wire module_run_next = (attach_reg || host_en_reg) && !idle_halt;

   // Frame timer wrap; frames stop whenever the module is halted
   wire sof_wrap = (sof_cnt_reg == 32'(SOF_CYCLES - 1));
   wire sof_active = host_en_reg && sof_en_reg && module_run_next;

   // Control register: device view bits
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pkt_dis_reg <= 1'b0;
         attach_reg <= 1'b0;
      end else begin
         if (wr_ctrl && !host_en_reg) begin
            attach_reg <= reg_wdata[uoc_pkg::BIT_ATTACH];
            pkt_dis_reg <= reg_wdata[uoc_pkg::BIT_PKT_DIS];
         end
         // A SETUP arriving during a clearing write still wins
         if (setup_token_seen && !host_en_reg)
            pkt_dis_reg <= 1'b1;
      end
   end

   // Control register: host view bits
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         bus_reset_reg <= 1'b0;
         sof_en_reg <= 1'b0;
      end else if (wr_ctrl && host_en_reg) begin
         bus_reset_reg <= reg_wdata[uoc_pkg::BIT_BUS_RESET];
         sof_en_reg <= reg_wdata[uoc_pkg::BIT_SOF_EN];
      end
   end

   // Control register: bits shared by both views
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         host_en_reg <= 1'b0;
         resume_reg <= 1'b0;
         ptr_reset_reg <= 1'b0;
      end else if (wr_ctrl) begin
         host_en_reg <= reg_wdata[uoc_pkg::BIT_HOST_EN];
         resume_reg <= reg_wdata[uoc_pkg::BIT_RESUME];
         ptr_reset_reg <= reg_wdata[uoc_pkg::BIT_PTR_RESET];
      end
   end

   // Token busy: launch sets, completion clears; launch wins a tie
   always_ff @(posedge ref_clk) begin
      if (reset)
         tok_busy_reg <= 1'b0;
      else if (tok_launch)
         tok_busy_reg <= 1'b1;
      else if (token_done || !host_en_reg)
         tok_busy_reg <= 1'b0;
   end

   // Address, token, threshold and configuration registers
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         addr_reg <= 7'h00;
         low_speed_reg <= 1'b0;
         token_reg <= 8'h00;
         thresh_reg <= 8'h00;
         eye_reg <= 1'b0;
         oe_mon_reg <= 1'b0;
         stop_idle_reg <= 1'b0;
         ppb_reg <= 2'h0;
         xcvr_dis_reg <= 1'b0;
      end else begin
         if (wr_addr) begin
            addr_reg <= reg_wdata[uoc_pkg::ADDR_MSB:0];
            low_speed_reg <= host_en_reg && reg_wdata[uoc_pkg::BIT_LOW_SPEED];
         end
         // A token write while one is running is dropped to keep fields stable
         if (wr_tok && !tok_busy_reg)
            token_reg <= reg_wdata[7:0];
         if (wr_sof)
            thresh_reg <= reg_wdata[7:0];
         if (wr_cfg) begin
            eye_reg <= reg_wdata[uoc_pkg::BIT_EYE_TEST];
            oe_mon_reg <= reg_wdata[uoc_pkg::BIT_OE_MON];
            stop_idle_reg <= reg_wdata[uoc_pkg::BIT_STOP_IDLE];
            ppb_reg <= reg_wdata[uoc_pkg::PPB_MSB:0];
         end
         if (wr_xcvr)
            xcvr_dis_reg <= reg_wdata[uoc_pkg::BIT_XCVR_DIS];
      end
   end

   // Frame timer: restarts whenever frame generation is off
   always_ff @(posedge ref_clk) begin
      if (reset || !sof_active || sof_wrap)
         sof_cnt_reg <= 32'h00000000;
      else
         sof_cnt_reg <= sof_cnt_reg + 32'h00000001;
   end

   // Read word for each view; unimplemented bits stay zero
   wire [15:0] ctrl_dev = {8'h00, 1'b0, se0_live, pkt_dis_reg, 1'b0, host_en_reg,
      resume_reg, ptr_reset_reg, attach_reg};
   wire [15:0] ctrl_host = {8'h00, j_live, se0_live, tok_busy_reg, bus_reset_reg,
      host_en_reg, resume_reg, ptr_reset_reg, sof_en_reg};
   wire [15:0] ctrl_word = host_en_reg ? ctrl_host : ctrl_dev;
   wire [15:0] addr_word = {8'h00, low_speed_reg && host_en_reg, addr_reg};
   wire [15:0] cfg_word = {8'h00, eye_reg, oe_mon_reg, 1'b0, stop_idle_reg, 2'h0,
      ppb_reg};
   wire [15:0] xcvr_word = {15'h0000, xcvr_dis_reg};
   wire [15:0] rd_word = (reg_addr == uoc_pkg::ADDR_CONTROL) ? ctrl_word
      : (reg_addr == uoc_pkg::ADDR_FUNC_ADDR) ? addr_word
      : (reg_addr == uoc_pkg::ADDR_TOKEN) ? {8'h00, token_reg}
      : (reg_addr == uoc_pkg::ADDR_SOF_THRESH) ? {8'h00, thresh_reg}
      : (reg_addr == uoc_pkg::ADDR_CONFIG_FIRST) ? cfg_word
      : (reg_addr == uoc_pkg::ADDR_CONFIG_XCVR) ? xcvr_word
      : uoc_pkg::RESET_WORD;

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge ref_clk) begin
      if (reset || !reg_read)
         reg_rdata <= uoc_pkg::RESET_WORD;
      else
         reg_rdata <= rd_word;
   end

   // Ping-pong decode
   wire pp_ep0_out = (ppb_reg == uoc_pkg::PPB_EP0_OUT) || (ppb_reg == uoc_pkg::PPB_ALL);
   wire pp_ep0_in = (ppb_reg == uoc_pkg::PPB_ALL);
   wire pp_upper = (ppb_reg == uoc_pkg::PPB_ALL) || (ppb_reg == uoc_pkg::PPB_EP1_15);

   // Monitor only means anything when the external transceiver is in use
   wire oe_mon_on = oe_mon_reg && xcvr_dis_reg;

   // Registered outputs; all but the token launch outputs lag their register by one cycle
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         module_run <= 1'b0;
         dp_pullup_on <= 1'b0;
         dp_pulldown_on <= 1'b0;
         dm_pulldown_on <= 1'b0;
         engine_halt <= 1'b0;
         resume_drive <= 1'b0;
         bus_reset_drive <= 1'b0;
         low_speed_mode <= 1'b0;
         device_address <= 7'h00;
         token_start <= 1'b0;
         token_type_code <= 4'h0;
         token_endpoint_number <= 4'h0;
         sof_send <= 1'b0;
         frame_threshold_count <= 8'h00;
         eye_test_run <= 1'b0;
         xcvr_off <= 1'b0;
         drive_oe_n <= 1'b1;
         ptr_force_even <= 1'b0;
         pp_ep0_out_en <= 1'b0;
         pp_ep0_in_en <= 1'b0;
         pp_ep_upper_en <= 1'b0;
      end else begin
         module_run <= module_run_next;
         dp_pullup_on <= attach_reg && !host_en_reg;
         dp_pulldown_on <= host_en_reg;
         dm_pulldown_on <= host_en_reg;
         engine_halt <= (pkt_dis_reg && !host_en_reg) || idle_halt;
         resume_drive <= resume_reg && module_run_next;
         bus_reset_drive <= bus_reset_reg && host_en_reg;
         low_speed_mode <= low_speed_reg && host_en_reg;
         device_address <= addr_reg;
         token_start <= tok_launch;
         token_type_code <= tok_launch ? new_type : token_reg[7:4];
         token_endpoint_number <= tok_launch ? reg_wdata[3:0] : token_reg[3:0];
         sof_send <= sof_active && sof_wrap;
         frame_threshold_count <= thresh_reg;
         eye_test_run <= eye_reg && module_run_next;
         xcvr_off <= xcvr_dis_reg;
         drive_oe_n <= !(oe_mon_on && tx_driving);
         ptr_force_even <= ptr_reset_reg;
         pp_ep0_out_en <= pp_ep0_out;
         pp_ep0_in_en <= pp_ep0_in;
         pp_ep_upper_en <= pp_upper;
      end
   end

   // Checks on the block's own outputs and internal registers
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   se0_flag_a: assert property ((reg_read && reg_addr == uoc_pkg::ADDR_CONTROL)
      |=> reg_rdata[uoc_pkg::BIT_SE0] == $past(se0_live))
      else $error("SE0 flag does not follow the line");
   setup_sets_a: assert property ((setup_token_seen && !host_en_reg)
      |=> pkt_dis_reg ##1 engine_halt)
      else $error("SETUP did not disable packets");
   host_pulls_a: assert property ($rose(host_en_reg)
      |=> dp_pulldown_on && dm_pulldown_on && !dp_pullup_on)
      else $error("Host pull-downs not applied");
   ptr_even_a: assert property (ptr_reset_reg |=> ptr_force_even)
      else $error("Pointer reset not forced");
   attach_a: assert property ((wr_ctrl && !host_en_reg && reg_wdata[0]
      && !reg_wdata[uoc_pkg::BIT_HOST_EN]) |=> ##1 dp_pullup_on)
      else $error("Attach pull-up missing");
   tok_busy_a: assert property (tok_launch |=> tok_busy_reg && token_start)
      else $error("Token launch not flagged busy");
   busy_hold_a: assert property ((tok_busy_reg && !token_done && host_en_reg)
      |=> tok_busy_reg)
      else $error("Token busy dropped early");
   sof_gap_a: assert property (sof_send |=> !sof_send [*8])
      else $error("Frame start too soon");
   sof_off_a: assert property (!sof_en_reg [*2] |-> !sof_send)
      else $error("Frame start while disabled");
   addr_low_a: assert property ((reg_read && reg_addr == uoc_pkg::ADDR_FUNC_ADDR
      && !host_en_reg) |=> !reg_rdata[uoc_pkg::BIT_LOW_SPEED])
      else $error("Low-speed bit visible in device mode");
   speed_out_a: assert property ((low_speed_reg && host_en_reg) |=> low_speed_mode)
      else $error("Low speed not applied in host mode");
   addr_out_a: assert property (wr_addr |=> ##1 (device_address
      == $past(reg_wdata[uoc_pkg::ADDR_MSB:0], 2)))
      else $error("Device address not presented");
   xcvr_out_a: assert property (wr_xcvr |=> ##1 (xcvr_off
      == $past(reg_wdata[uoc_pkg::BIT_XCVR_DIS], 2)))
      else $error("Transceiver disable not presented");
   eye_stop_a: assert property (!eye_reg |=> !eye_test_run)
      else $error("Eye test ran while disabled");
   pp_all_a: assert property ((ppb_reg == uoc_pkg::PPB_ALL)
      |=> pp_ep0_out_en && pp_ep0_in_en && pp_ep_upper_en)
      else $error("Ping-pong all-endpoint decode wrong");
   pp_none_a: assert property ((ppb_reg == uoc_pkg::PPB_NONE)
      |=> !(pp_ep0_out_en || pp_ep0_in_en || pp_ep_upper_en))
      else $error("Ping-pong decode active while off");
   bad_code_a: assert property ((wr_tok && !type_ok) |=> !token_start)
      else $error("Reserved token code launched");
   oe_mon_a: assert property ((!oe_mon_reg || !xcvr_dis_reg) |=> drive_oe_n)
      else $error("Monitor active without external transceiver");
   idle_stop_a: assert property ((stop_idle_reg && cpu_idle) |=> !module_run)
      else $error("Module ran in idle");
   upper_zero_a: assert property (reg_read |=> reg_rdata[15:8] == 8'h00)
      else $error("Upper byte not zero");

   setup_seen_c: cover property (setup_token_seen && !host_en_reg);
   token_run_c: cover property (tok_launch ##[1:50] token_done);
   sof_tick_c: cover property (sof_send);
   oe_drive_c: cover property (!drive_oe_n);

endmodule

// File: src/uoc_pkg.sv
// Purpose: Shared constants for the USB control and configuration block.
// Assumes: 16-bit register words on a plain strobe port, 10 MHz clock.
// Notes: Register indices are word addresses on the local port.
package uoc_pkg;
   // Register word addresses
   localparam logic [3:0] ADDR_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_FUNC_ADDR = 4'h1;
   localparam logic [3:0] ADDR_TOKEN = 4'h2;
   localparam logic [3:0] ADDR_SOF_THRESH = 4'h3;
   localparam logic [3:0] ADDR_CONFIG_FIRST = 4'h4;
   localparam logic [3:0] ADDR_CONFIG_XCVR = 4'h5;
   // Control register fields, both views
   localparam int BIT_J_STATE = 7;
   localparam int BIT_SE0 = 6;
   localparam int BIT_PKT_DIS = 5;
   localparam int BIT_TOK_BUSY = 5;
   localparam int BIT_BUS_RESET = 4;
   localparam int BIT_HOST_EN = 3;
   localparam int BIT_RESUME = 2;
   localparam int BIT_PTR_RESET = 1;
   localparam int BIT_ATTACH = 0;
   localparam int BIT_SOF_EN = 0;
   // Address, token and configuration fields
   localparam int BIT_LOW_SPEED = 7;
   localparam int ADDR_MSB = 6;
   localparam int TOK_TYPE_LSB = 4;
   localparam int BIT_EYE_TEST = 7;
   localparam int BIT_OE_MON = 6;
   localparam int BIT_STOP_IDLE = 4;
   localparam int PPB_MSB = 1;
   localparam int BIT_XCVR_DIS = 0;
   // Values after reset
   localparam logic [15:0] RESET_WORD = 16'h0000;
   // Token type codes; all other codes are reserved
   typedef enum logic [3:0] {
      TOK_OUT = 4'h1,
      TOK_IN = 4'h9,
      TOK_SETUP = 4'hD
   } uoc_token_e;
   // Ping-pong configuration codes
   localparam logic [1:0] PPB_NONE = 2'h0;
   localparam logic [1:0] PPB_EP0_OUT = 2'h1;
   localparam logic [1:0] PPB_ALL = 2'h2;
   localparam logic [1:0] PPB_EP1_15 = 2'h3;
   // Frame timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int SOF_PERIOD_NS = 1000000;
   localparam int SOF_PERIOD_CYCLES = SOF_PERIOD_NS / CLK_PERIOD_NS;
endpackage

// File: tb/uoc_bus_model.sv
// Purpose: Behavioural far side of the USB lines and the serial engine.
// Assumes: The bench picks the line state; every token ends after a fixed delay.
// Notes: A setup request from the bench comes out one cycle later as a pulse.
`timescale 1ns/1ps
module uoc_bus_model #(
   parameter int DONE_DLY = 8
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Bench controls and token launch
   input wire logic [1:0] line_sel,
   input wire logic setup_req,
   input wire logic token_start,
   // Line levels and engine events
   output logic line_dp,
   output logic line_dm,
   output logic setup_token_seen,
   output logic token_done,
   output logic tx_driving
);
   int cnt;
   // Line state: 0 full-speed J, 1 single-ended zero, 2 low-speed J
   assign line_dp = (line_sel == 2'h0);
   assign line_dm = (line_sel == 2'h2);
   // Lines are driven from launch until the transaction ends
   assign tx_driving = (cnt != 0);
   // Token timer; a slow device keeps the host busy for DONE_DLY+2 cycles
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cnt <= 0;
         token_done <= 1'b0;
         setup_token_seen <= 1'b0;
      end else begin
         cnt <= token_start ? DONE_DLY : ((cnt != 0) ? cnt - 1 : 0);
         token_done <= (cnt == 1);
         setup_token_seen <= setup_req;
      end
   end
endmodule

// File: tb/uoc_ctrl_tb_top.sv
// Purpose: Self-checking bench for the USB control and configuration block.
// Assumes: Register port answers reads one cycle later; SOF period cut to 20.
// Notes: Token launch outputs are checked right after a write; others two cycles after, when derived logic has settled.
`timescale 1ns/1ps
module uoc_ctrl_tb_top;
   localparam int SOF_N = 20;
   logic ref_clk, reset, reg_write, reg_read, cpu_idle, setup_req;
   logic [3:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, rd_val;
   logic [1:0] line_sel;
   logic line_dp, line_dm, setup_token_seen, token_done, tx_driving;
   logic module_run, dp_pullup_on, dp_pulldown_on, dm_pulldown_on, engine_halt;
   logic resume_drive, bus_reset_drive, low_speed_mode, token_start, sof_send;
   logic eye_test_run, xcvr_off, drive_oe_n, ptr_force_even;
   logic pp_ep0_out_en, pp_ep0_in_en, pp_ep_upper_en;
   logic [6:0] device_address;
   logic [3:0] token_type_code, token_endpoint_number;
   logic [7:0] frame_threshold_count;
   int n_mismatch, compares, cyc, tok_cnt, sof_cnt, t0;
   logic [3:0] codes [3];
   logic [2:0] pp_exp [4];

   uoc_ctrl #(.SOF_CYCLES(SOF_N)) u_uoc_ctrl (.ref_clk(ref_clk), .reset(reset),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .line_dp(line_dp), .line_dm(line_dm),
      .setup_token_seen(setup_token_seen), .token_done(token_done),
      .tx_driving(tx_driving), .cpu_idle(cpu_idle), .module_run(module_run),
      .dp_pullup_on(dp_pullup_on), .dp_pulldown_on(dp_pulldown_on),
      .dm_pulldown_on(dm_pulldown_on), .engine_halt(engine_halt),
      .resume_drive(resume_drive), .bus_reset_drive(bus_reset_drive),
      .low_speed_mode(low_speed_mode), .device_address(device_address),
      .token_start(token_start), .token_type_code(token_type_code),
      .token_endpoint_number(token_endpoint_number), .sof_send(sof_send),
      .frame_threshold_count(frame_threshold_count), .eye_test_run(eye_test_run),
      .xcvr_off(xcvr_off), .drive_oe_n(drive_oe_n), .ptr_force_even(ptr_force_even),
      .pp_ep0_out_en(pp_ep0_out_en), .pp_ep0_in_en(pp_ep0_in_en),
      .pp_ep_upper_en(pp_ep_upper_en));

   uoc_bus_model u_uoc_bus_model (.ref_clk(ref_clk), .reset(reset), .line_sel(line_sel),
      .setup_req(setup_req), .token_start(token_start), .line_dp(line_dp),
      .line_dm(line_dm), .setup_token_seen(setup_token_seen), .token_done(token_done),
      .tx_driving(tx_driving));

   // 10 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // Cycle, token launch and frame pulse counters
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      tok_cnt <= tok_cnt + int'(token_start === 1'b1);
      sof_cnt <= sof_cnt + int'(sof_send === 1'b1);
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // One-cycle write strobe; returns at the edge that takes it
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_write <= 1'b0;
   endtask

   // Read data is looked at mid-cycle after the taking edge, its only valid cycle
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge ref_clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_read <= 1'b0;
      @(negedge ref_clk);
      chk(reg_rdata, exp);
   endtask

   task automatic settle();
      repeat (2) @(negedge ref_clk);
   endtask

   task automatic final_report();
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Watchdog well beyond the few hundred cycles the tests need
   initial begin
      #(100 * 20000);
      n_mismatch++;
      final_report();
   end

   initial begin
      {reg_write, reg_read, cpu_idle, setup_req} = 4'h0;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      line_sel = 2'h0;
      {cyc, tok_cnt, sof_cnt, n_mismatch, compares} = '0;
      codes = '{4'hD, 4'h9, 4'h1};
      pp_exp = '{3'h0, 3'h4, 3'h7, 3'h1};
      reset = 1'b1;
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      // Let the line synchroniser fill so no stale single-ended zero is read
      repeat (2) @(posedge ref_clk);
      for (int a = 0; a < 7; a++) rd(a[3:0], 16'h0000);
      wr(4'h1, 16'hFFFF);
      rd(4'h1, 16'h007F);
      chk({9'h0, device_address}, 16'h007F);
      // Device view: all writable bits set, host enable left clear
      wr(4'h0, 16'hFFF7);
      rd(4'h0, 16'h0027);
      chk({engine_halt, ptr_force_even, dp_pullup_on, resume_drive}, 16'hF);
      wr(4'h0, 16'h0001);
      settle();
      chk({engine_halt, ptr_force_even, module_run}, 16'h1);
      @(posedge ref_clk) setup_req <= 1'b1;
      @(posedge ref_clk) setup_req <= 1'b0;
      line_sel <= 2'h1;
      repeat (3) @(posedge ref_clk);
      rd(4'h0, 16'h0061);
      chk(engine_halt, 1'b1);
      @(posedge ref_clk) line_sel <= 2'h0;
      // Host mode: pull-downs on, pull-up off, live J flag
      wr(4'h0, 16'h0008);
      rd(4'h0, 16'h0088);
      chk({dp_pulldown_on, dm_pulldown_on, dp_pullup_on}, 16'h6);
      wr(4'h1, 16'h0085);
      rd(4'h1, 16'h0085);
      chk(low_speed_mode, 1'b1);
      rd(4'h0, 16'h0008);
      @(posedge ref_clk) line_sel <= 2'h2;
      repeat (3) @(posedge ref_clk);
      rd(4'h0, 16'h0088);
      @(posedge ref_clk) line_sel <= 2'h0;
      wr(4'h1, 16'h0000);
      // Each token code launches once; a write while busy is dropped
      // Endpoints 3, 9 and 15 stand for ones that the far device really has
      for (int i = 0; i < 3; i++) begin
         wr(4'h2, {8'h00, codes[i], 4'(i * 6 + 3)});
         @(negedge ref_clk);
         chk({token_start, token_type_code, token_endpoint_number},
             {7'h0, 1'b1, codes[i], 4'(i * 6 + 3)});
         rd(4'h0, 16'h00A8);
         wr(4'h2, 16'h0091);
         repeat (15) @(posedge ref_clk);
         rd(4'h0, 16'h0088);
         chk(16'(tok_cnt), 16'(i + 1));
      end
      wr(4'h2, 16'h0024);
      settle();
      chk(16'(tok_cnt), 16'h0003);
      rd(4'h2, 16'h0024);
      // Frame start every SOF_N cycles, none once disabled
      wr(4'h0, 16'h0009);
      for (int i = 0; i < 100 && sof_send !== 1'b1; i++) @(negedge ref_clk);
      t0 = cyc;
      @(negedge ref_clk);
      for (int i = 0; i < 100 && sof_send !== 1'b1; i++) @(negedge ref_clk);
      chk(16'(cyc - t0), 16'(SOF_N));
      wr(4'h0, 16'h0008);
      t0 = sof_cnt;
      repeat (60) @(posedge ref_clk);
      chk(16'(sof_cnt), 16'(t0));
      // Software bus reset and resume, kept short here
      wr(4'h0, 16'h001C);
      rd(4'h0, 16'h009C);
      chk({bus_reset_drive, resume_drive}, 16'h3);
      wr(4'h0, 16'h0008);
      wr(4'h3, 16'h124A);
      rd(4'h3, 16'h004A);
      chk(frame_threshold_count, 8'h4A);
      wr(4'h4, 16'hFFFF);
      rd(4'h4, 16'h00D3);
      chk(eye_test_run, 1'b1);
      for (int p = 0; p < 4; p++) begin
         wr(4'h4, 16'(p));
         settle();
         chk({pp_ep0_out_en, pp_ep0_in_en, pp_ep_upper_en}, pp_exp[p]);
      end
      chk(eye_test_run, 1'b0);
      @(posedge ref_clk) cpu_idle <= 1'b1;
      wr(4'h4, 16'h0010);
      settle();
      chk(module_run, 1'b0);
      wr(4'h4, 16'h0000);
      settle();
      chk(module_run, 1'b1);
      @(posedge ref_clk) cpu_idle <= 1'b0;
      // Monitor shows line driving only with the transceiver off
      for (int x = 1; x >= 0; x--) begin
         wr(4'h5, 16'(x));
         wr(4'h4, 16'h0040);
         wr(4'h2, 16'h0012);
         repeat (3) @(negedge ref_clk);
         chk({xcvr_off, drive_oe_n}, {x[0], ~x[0]});
         repeat (15) @(posedge ref_clk);
         chk(drive_oe_n, 1'b1);
      end
      wr(4'h0, 16'h0000);
      settle();
      chk({dp_pulldown_on, dm_pulldown_on}, 16'h0);
      final_report();
   end
endmodule
